// ==== dv/dma_model.sv ====
// Behavioural DMA controller serving the decoder's request events.
`timescale 1ns/1ps
module dma_model
   import tdf_pkg::*;
(
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire logic                       en,
   input  wire logic                       slow,
   input  wire logic                       input_request_event,
   input  wire logic                       output_ready_event,
   input  wire logic [tdf_pkg::DATA_W-1:0] bus_rdata,
   input  wire logic [tdf_pkg::DATA_W-1:0] cfg_word0,
   input  wire logic [tdf_pkg::DATA_W-1:0] cfg_word1,
   output logic      [tdf_pkg::ADDR_W-1:0] dma_addr,
   output logic      [tdf_pkg::DATA_W-1:0] dma_wdata,
   output logic                            dma_wr,
   output logic                            dma_rd,
   output logic                            busy,
   output int                              n_in,
   output int                              n_out
);
   logic [31:0] ext_mem [0:255];
   logic [31:0] par_mem [0:1];
   int          served_in;
   int          served_out;
   logic        ext_next;
   // ----------------------------------------------------------------
   // Event capture and transfers
   // ----------------------------------------------------------------
   // Events are counted apart from the transfer engine so that a pulse
   // landing while a transfer runs is never lost.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         n_in <= 0;
         n_out <= 0;
      end else begin
         if (input_request_event) n_in <= n_in + 1;
         if (output_ready_event) n_out <= n_out + 1;
      end
   end
   function automatic logic [31:0] src(input int kind, input int i);
      case (kind)
         0: src = (i == 0) ? cfg_word0 : (i == 1) ? cfg_word1 :
                  32'h00c0_0000 | 32'(i);
         1: src = 32'h5500_0000 + 32'(i);
         default: src = 32'h8100_0000 + 32'(i);
      endcase
   endfunction
   task automatic put(input int kind, input logic [7:0] a,
                      input logic inc, input int n);
      for (int i = 0; i < n; i++) begin
         dma_wr <= 1'b1;
         dma_addr <= inc ? a + 8'(4 * i) : a;
         dma_wdata <= src(kind, i);
         @(posedge ref_clk);
      end
   endtask
   task automatic get(input logic [7:0] a, input int n, input logic par);
      for (int i = 0; i <= n; i++) begin
         dma_rd <= (i < n);
         dma_addr <= (i < n) ? a : ~a;
         @(posedge ref_clk);
         if (i > 0 && par) par_mem[i-1] = bus_rdata;
         else if (i > 0) ext_mem[i-1] = bus_rdata;
      end
   endtask
   initial begin
      dma_wr = 1'b0;
      dma_rd = 1'b0;
      dma_addr = '0;
      dma_wdata = '0;
      busy = 1'b0;
      served_in = 0;
      served_out = 0;
      ext_next = 1'b1;
      forever begin
         @(posedge ref_clk);
         if (!rst_n) begin
            served_in = 0;
            served_out = 0;
         end else if (en && (n_in != served_in || n_out != served_out)) begin
            busy <= 1'b1;
            if (slow) repeat (3) @(posedge ref_clk);
            if (n_in != served_in) begin
               if (served_in % 2 == 0) begin
                  put(0, ADDR_CFG0, 1'b1, 12);
                  ext_next = 1'b1;
               end else begin
                  put(1, ADDR_SP, 1'b0, int'(cfg_word1[15:0]));
                  put(2, ADDR_AP, 1'b0,
                      (int'(cfg_word0[15:0]) + 3) / 4);
               end
               served_in++;
            end else begin
               if (ext_next) get(ADDR_EXT, (int'(cfg_word0[15:0]) + 3) / 4,
                                 1'b0);
               else get(ADDR_PARAMETER_RAM, 2, 1'b1);
               ext_next = 1'b0;
               served_out++;
            end
            dma_wr <= 1'b0;
            dma_wdata <= ~dma_wdata;
            busy <= 1'b0;
         end
      end
   end
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the turbo decoder data feed.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      fails++; \
      $display("[FAIL] %0t %s", $time, msg); \
   end \
end
module testbench;
   import tdf_pkg::*;
   typedef struct {
      logic [15:0] fl;
      logic        output_params_flag;
      logic        estop;
      logic [3:0]  max_iterations;
      logic [15:0] spw;
      logic        slow;
      logic [3:0]  mask;
      logic        exp_irq;
      logic [3:0]  exp_st;
   } row_t;
   logic        ref_clk, rst_n, en, slow, h_wr, h_rd, d_wr, d_rd, dbusy;
   logic        irq, input_request_event, output_ready_event;
   logic [7:0]  h_addr, d_addr;
   logic [31:0] h_wdata, d_wdata, bus_rdata, cfg0, cfg1, v;
   int          fails, n_tests, tot_in, tot_out, n_in, n_out;
   row_t rows[4] = '{
      '{16'd378, 1'b1, 1'b1, 4'd8, 16'd378, 1'b0, 4'hf, 1'b1, 4'h7},
      '{16'd40, 1'b0, 1'b0, 4'd1, 16'd80, 1'b1, 4'h0, 1'b0, 4'h7},
      '{16'd5, 1'b1, 1'b0, 4'd15, 16'd1, 1'b1, 4'h4, 1'b1, 4'h7},
      '{16'd128, 1'b0, 1'b1, 4'd4, 16'd256, 1'b0, 4'h2, 1'b1, 4'h7}};
   turbo_decoder_dma_feed turbo_decoder_dma_feed_i (
      .ref_clk(ref_clk), .rst_n(rst_n),
      .bus_addr(dbusy ? d_addr : h_addr),
      .bus_wdata(dbusy ? d_wdata : h_wdata),
      .bus_wr(dbusy ? d_wr : h_wr), .bus_rd(dbusy ? d_rd : h_rd),
      .bus_rdata(bus_rdata), .input_request_event(input_request_event),
      .output_ready_event(output_ready_event), .irq(irq));
   dma_model dma_model_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .en(en), .slow(slow),
      .input_request_event(input_request_event),
      .output_ready_event(output_ready_event), .bus_rdata(bus_rdata),
      .cfg_word0(cfg0), .cfg_word1(cfg1), .dma_addr(d_addr),
      .dma_wdata(d_wdata), .dma_wr(d_wr), .dma_rd(d_rd), .busy(dbusy),
      .n_in(n_in), .n_out(n_out));
   // ----------------------------------------------------------------
   // Host bus tasks
   // ----------------------------------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      h_wr <= 1'b1;
      h_addr <= a;
      h_wdata <= d;
      @(posedge ref_clk);
      h_wr <= 1'b0;
      h_addr <= 8'h00;
      @(posedge ref_clk);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      h_rd <= 1'b1;
      h_addr <= a;
      @(posedge ref_clk);
      h_rd <= 1'b0;
      h_addr <= 8'h00;
      @(posedge ref_clk);
      d = bus_rdata;
   endtask
   task automatic print_verdict();
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic run(input row_t r);
      int nw;
      nw = (int'(r.fl) + 3) / 4;
      slow <= r.slow;
      cfg0 <= {10'h000, r.max_iterations, r.estop, r.output_params_flag, r.fl};
      cfg1 <= {16'h0000, r.spw};
      tot_in += 2;
      tot_out += 1 + int'(r.output_params_flag);
      wr_reg(ADDR_MASK, {28'h0, r.mask});
      wr_reg(ADDR_EXEC, 32'h1);
      for (int k = 0; k < 9000 && dma_model_i.served_out != tot_out; k++)
         @(posedge ref_clk);
      `CHK(dma_model_i.served_out, tot_out, "transfers done")
      repeat (3) @(posedge ref_clk);
      `CHK(irq, r.exp_irq, "irq level")
      rd_reg(ADDR_STATUS, v);
      `CHK(v[3:0], r.exp_st, "status after pass")
      @(posedge ref_clk);
      `CHK(irq, 1'b0, "irq after status read")
      for (int i = 0; i < nw; i++)
         `CHK(dma_model_i.ext_mem[i], 32'h8100_0000 + 32'(i), "ext")
      if (r.output_params_flag) begin
         `CHK(dma_model_i.par_mem[0], {r.estop, 27'h0, r.max_iterations}, "it")
         `CHK(dma_model_i.par_mem[1], {16'h0, r.fl}, "parameter_ram fl")
      end
      `CHK(n_in, tot_in, "request events")
      `CHK(n_out, tot_out, "ready events")
      rd_reg(ADDR_EXEC, v);
      `CHK(v[2:0], 3'h0, "phase idle after pass")
      rd_reg(ADDR_ITER, v);
      `CHK(v[3:0], r.max_iterations, "iteration count")
      rd_reg(ADDR_CFG0 + 8'h04, v);
      `CHK(v, {16'h0000, r.spw}, "config word one")
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      fails++;
      print_verdict();
   end
   initial begin
      rst_n = 1'b0;
      en = 1'b1;
      slow = 1'b0;
      h_wr = 1'b0;
      h_rd = 1'b0;
      h_addr = '0;
      h_wdata = '0;
      cfg0 = '0;
      cfg1 = '0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      foreach (rows[r]) run(rows[r]);
      // Second reset, then refusals, then a third reset and a start with zero frame length.
      rst_n <= 1'b0;
      @(posedge ref_clk);
      `CHK({bus_rdata, input_request_event, output_ready_event, irq},
           35'h0, "outputs in reset")
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd_reg(ADDR_MASK, v);
      `CHK(v[3:0], MASK_RST, "mask reset")
      wr_reg(ADDR_CFG0, 32'h1234_5678);
      wr_reg(8'h14, 32'hffff_ffff);
      rd_reg(ADDR_CFG0, v);
      `CHK(v, 32'h0, "config written before start")
      rd_reg(8'h10, v);
      `CHK(v, 32'h0, "unmapped read")
      rd_reg(ADDR_EXT, v);
      `CHK(v, 32'h0, "extrinsic read outside phase")
      rd_reg(ADDR_STATUS, v);
      `CHK(v[3:0], 4'h8, "early config error")
      rd_reg(ADDR_STATUS, v);
      `CHK(v[3:0], 4'h0, "status read clears")
      en <= 1'b0;
      wr_reg(ADDR_EXEC, 32'h1);
      `CHK(input_request_event, 1'b1, "request after start")
      wr_reg(ADDR_EXEC, 32'h1);
      `CHK(input_request_event, 1'b0, "second start ignored")
      rd_reg(ADDR_EXEC, v);
      `CHK(v[2:0], 3'h1, "config phase")
      wr_reg(ADDR_SP, 32'h0);
      rd_reg(ADDR_STATUS, v);
      `CHK(v[IRQ_ERR], 1'b1, "data during config phase")
      rst_n <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      en <= 1'b1;
      cfg0 <= 32'h0;
      cfg1 <= 32'h5;
      @(posedge ref_clk);
      wr_reg(ADDR_EXEC, 32'h1);
      repeat (30) @(posedge ref_clk);
      rd_reg(ADDR_STATUS, v);
      `CHK(v[IRQ_ERR], 1'b1, "zero frame length")
      rd_reg(ADDR_EXEC, v);
      `CHK(v[2:0], 3'h0, "idle after bad config")
      print_verdict();
   end
endmodule

// ==== inc/tdf_pkg.sv ====
// Shared constants and types for the turbo decoder data feed.
package tdf_pkg;
   // ----------------------------------------------------------------
   // Bus and data widths
   // ----------------------------------------------------------------
   localparam int ADDR_W       = 8;
   localparam int DATA_W       = 32;
   localparam int LLR_W        = 8;
   localparam int LLR_PER_WORD = DATA_W / LLR_W;
   localparam int CNT_W        = 16;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_EXEC   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_ITER   = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_CFG0   = 8'h40;
   localparam logic [ADDR_W-1:0] ADDR_SP     = 8'h80;
   localparam logic [ADDR_W-1:0] ADDR_AP     = 8'h84;
   localparam logic [ADDR_W-1:0] ADDR_EXT    = 8'h88;
   localparam logic [ADDR_W-1:0] ADDR_PARAMETER_RAM  = 8'h8c;
   localparam logic [CNT_W-1:0]  CFG_WORDS   = 16'h000c;
   localparam logic [CNT_W-1:0]  PARAMETER_RAM_WORDS = 16'h0002;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int START_BIT  = 0;
   localparam int FL_LSB     = 0;
   localparam int OUTPUT_PARAMS_FLAG_BIT   = 16;
   localparam int ESTOP_BIT  = 17;
   localparam int MAX_ITERATIONS_LSB  = 18;
   localparam int MAX_ITERATIONS_W    = 4;
   localparam int SPCNT_LSB  = 0;
   localparam int IRQ_CFG    = 0;
   localparam int IRQ_MAP    = 1;
   localparam int IRQ_DONE   = 2;
   localparam int IRQ_ERR    = 3;
   localparam int IRQ_W      = 4;
   localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int MAP_TIME_NS   = 64;
   localparam logic [CNT_W-1:0] MAP_CYCLES =
      CNT_W'((MAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ----------------------------------------------------------------
   // Phases
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CFG   = 3'b001,
      ST_SP    = 3'b010,
      ST_AP    = 3'b011,
      ST_MAP   = 3'b100,
      ST_EXT   = 3'b101,
      ST_PARAMETER_RAM = 3'b110
   } phase_t;
endpackage

// ==== rtl/llr_buffer.sv ====
// Word buffer holding packed a-priori LLRs for one MAP pass.
`timescale 1ns/1ps
module llr_buffer #(
   parameter int DEPTH  = 1024,
   parameter int AW     = 10,
   parameter int DATA_W = 32
) (
   input  wire logic              ref_clk,
   input  wire logic              we,
   input  wire logic [AW-1:0]     waddr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [AW-1:0]     raddr,
   output logic      [DATA_W-1:0] rdata
);
   if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_bad_depth
      $error("llr_buffer depth does not fit its address width");
   end

   logic [DATA_W-1:0] mem [DEPTH];

   // Storage only, no reset: contents are always rewritten before use.
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule

// ==== rtl/turbo_decoder_dma_feed.sv ====
// Event-driven DMA data interface of the turbo decoder, single MAP pass.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module turbo_decoder_dma_feed
   import tdf_pkg::*;
#(
   parameter int BUF_DEPTH = 1024,
   parameter int BUF_AW    = 10
) (
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire logic [tdf_pkg::ADDR_W-1:0] bus_addr,
   input  wire logic [tdf_pkg::DATA_W-1:0] bus_wdata,
   input  wire logic                       bus_wr,
   input  wire logic                       bus_rd,
   output logic      [tdf_pkg::DATA_W-1:0] bus_rdata,
   output logic                            input_request_event,
   output logic                            output_ready_event,
   output logic                            irq
);
   import tdf_pkg::*;

   if (BUF_AW > CNT_W || BUF_DEPTH > (1 << BUF_AW)) begin : g_bad_buf
      $error("buffer does not fit the word counter");
   end

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
      return (a >= ADDR_CFG0) &&
             (a < ADDR_CFG0 + ADDR_W'(CFG_WORDS << 2)) &&
             (a[1:0] == 2'b00);
   endfunction

   function automatic logic [3:0] cfg_index(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - ADDR_CFG0;
      return d[5:2];
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   phase_t               state_reg;
   phase_t               state_next;
   logic                 ireq_reg;
   logic                 ireq_next;
   logic                 ordy_reg;
   logic                 ordy_next;
   logic [DATA_W-1:0]    cfg_reg [12];
   logic [DATA_W-1:0]    cfg_next [12];
   logic [IRQ_W-1:0]     mask_reg;
   logic [IRQ_W-1:0]     mask_next;
   logic [IRQ_W-1:0]     status_reg;
   logic [IRQ_W-1:0]     status_next;
   logic [IRQ_W-1:0]     set_bits;
   logic                 irq_reg;
   logic                 irq_next;
   logic [DATA_W-1:0]    rdata_reg;
   logic [DATA_W-1:0]    rdata_next;
   logic                 cnt_load;
   logic [CNT_W-1:0]     cnt_len;
   logic                 cnt_step;
   logic [CNT_W-1:0]     cnt_idx;
   logic                 cnt_last;
   logic [DATA_W-1:0]    buf_rdata;
   logic [15:0]          frame_len;
   logic [CNT_W-1:0]     sp_words;
   logic [CNT_W-1:0]     llr_words;
   logic                 output_params_flag;
   logic                 estop;
   logic [MAX_ITERATIONS_W-1:0]   iter_run;
   logic                 wr_cfg;

   assign frame_len = cfg_reg[0][FL_LSB +: 16];
   assign output_params_flag      = cfg_reg[0][OUTPUT_PARAMS_FLAG_BIT];
   assign estop     = cfg_reg[0][ESTOP_BIT];
   assign sp_words  = cfg_reg[1][SPCNT_LSB +: CNT_W];
   // Four signed byte LLRs pack into each bus word.
   assign llr_words = CNT_W'(({1'b0, frame_len} + 17'h00003) >> 2);
   // Without early stop the full programmed count always runs.
   assign iter_run  = cfg_reg[0][MAX_ITERATIONS_LSB +: MAX_ITERATIONS_W];
   assign wr_cfg    = bus_wr && is_cfg(bus_addr);

   word_counter #(.CNT_W(CNT_W)) u_count (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .load    (cnt_load),
      .len     (cnt_len),
      .step    (cnt_step),
      .idx     (cnt_idx),
      .last    (cnt_last)
   );

   llr_buffer #(.DEPTH(BUF_DEPTH), .AW(BUF_AW), .DATA_W(DATA_W)) u_buf (
      .ref_clk (ref_clk),
      .we      (state_reg == ST_AP && bus_wr && bus_addr == ADDR_AP),
      .waddr   (cnt_idx[BUF_AW-1:0]),
      .wdata   (bus_wdata),
      .raddr   (cnt_idx[BUF_AW-1:0]),
      .rdata   (buf_rdata)
   );

   // ----------------------------------------------------------------
   // Phase sequencing
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      ireq_next  = 1'b0;
      ordy_next  = 1'b0;
      cnt_load   = 1'b0;
      cnt_len    = CFG_WORDS;
      cnt_step   = 1'b0;
      set_bits   = '0;
      case (state_reg)
         ST_IDLE: begin
            if (bus_wr && bus_addr == ADDR_EXEC && bus_wdata[START_BIT]) begin
               state_next = ST_CFG;
               ireq_next  = 1'b1;
               cnt_load   = 1'b1;
            end
         end
         ST_CFG: begin
            cnt_step = wr_cfg;
            if (cnt_last) begin
               set_bits[IRQ_CFG] = 1'b1;
               if (sp_words == '0 || llr_words == '0) begin
                  // A zero count would wrap the counter, so the phase would end only after 65536 words.
                  set_bits[IRQ_ERR] = 1'b1;
                  state_next = ST_IDLE;
               end else begin
                  state_next = ST_SP;
                  ireq_next  = 1'b1;
                  cnt_load   = 1'b1;
                  cnt_len    = sp_words;
               end
            end
         end
         ST_SP: begin
            cnt_step = bus_wr && bus_addr == ADDR_SP;
            if (cnt_last) begin
               // The a-priori data arrives by channel chaining.
               state_next = ST_AP;
               cnt_load   = 1'b1;
               cnt_len    = llr_words;
            end
         end
         ST_AP: begin
            cnt_step = bus_wr && bus_addr == ADDR_AP;
            if (cnt_last) begin
               state_next = ST_MAP;
               cnt_load   = 1'b1;
               cnt_len    = MAP_CYCLES;
            end
         end
         ST_MAP: begin
            cnt_step = 1'b1;
            if (cnt_last) begin
               state_next = ST_EXT;
               ordy_next  = 1'b1;
               cnt_load   = 1'b1;
               cnt_len    = llr_words;
               set_bits[IRQ_MAP] = 1'b1;
            end
         end
         ST_EXT: begin
            cnt_step = bus_rd && bus_addr == ADDR_EXT;
            if (cnt_last) begin
               if (output_params_flag) begin
                  state_next = ST_PARAMETER_RAM;
                  ordy_next  = 1'b1;
                  cnt_load   = 1'b1;
                  cnt_len    = PARAMETER_RAM_WORDS;
               end else begin
                  state_next = ST_IDLE;
                  set_bits[IRQ_DONE] = 1'b1;
               end
            end
         end
         ST_PARAMETER_RAM: begin
            cnt_step = bus_rd && bus_addr == ADDR_PARAMETER_RAM;
            if (cnt_last) begin
               state_next = ST_IDLE;
               set_bits[IRQ_DONE] = 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // Writes to config or data ports outside their phase are dropped.
      if ((wr_cfg && state_reg != ST_CFG) ||
          (bus_wr && bus_addr == ADDR_SP && state_reg != ST_SP) ||
          (bus_wr && bus_addr == ADDR_AP && state_reg != ST_AP)) begin
         set_bits[IRQ_ERR] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         ireq_reg  <= 1'b0;
         ordy_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         ireq_reg  <= ireq_next;
         ordy_reg  <= ordy_next;
      end
   end

   // ----------------------------------------------------------------
   // Register file and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      cfg_next  = cfg_reg;
      mask_next = mask_reg;
      if (wr_cfg && state_reg == ST_CFG) begin
         cfg_next[cfg_index(bus_addr)] = bus_wdata;
      end
      if (bus_wr && bus_addr == ADDR_MASK) begin
         mask_next = bus_wdata[IRQ_W-1:0];
      end
      // A new event in the clearing read cycle survives the clear.
      status_next = status_reg;
      if (bus_rd && bus_addr == ADDR_STATUS) begin
         status_next = '0;
      end
      status_next = status_next | set_bits;
      irq_next    = |(status_next & mask_next);
      rdata_next  = '0;
      if (bus_rd) begin
         if (is_cfg(bus_addr)) begin
            rdata_next = cfg_reg[cfg_index(bus_addr)];
         end else begin
            case (bus_addr)
               ADDR_EXEC:   rdata_next = DATA_W'(state_reg);
               ADDR_STATUS: rdata_next = DATA_W'(status_reg);
               ADDR_MASK:   rdata_next = DATA_W'(mask_reg);
               ADDR_ITER:   rdata_next = DATA_W'(iter_run);
               ADDR_EXT: begin
                  if (state_reg == ST_EXT) begin
                     rdata_next = buf_rdata;
                  end
               end
               ADDR_PARAMETER_RAM: begin
                  if (state_reg == ST_PARAMETER_RAM) begin
                     rdata_next = (cnt_idx == '0) ?
                        {estop, 27'h0000000, iter_run} :
                        DATA_W'(frame_len);
                  end
               end
               default: rdata_next = '0;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 12; i++) begin
            cfg_reg[i] <= '0;
         end
         mask_reg   <= MASK_RST;
         status_reg <= '0;
         irq_reg    <= 1'b0;
         rdata_reg  <= '0;
      end else begin
         cfg_reg    <= cfg_next;
         mask_reg   <= mask_next;
         status_reg <= status_next;
         irq_reg    <= irq_next;
         rdata_reg  <= rdata_next;
      end
   end

   assign bus_rdata           = rdata_reg;
   assign input_request_event = ireq_reg;
   assign output_ready_event  = ordy_reg;
   assign irq                 = irq_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_start_request: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == ST_IDLE && bus_wr && bus_addr == ADDR_EXEC &&
       bus_wdata[START_BIT])
      |=> input_request_event && state_reg == ST_CFG
   ) else $error("start did not raise the config request");

   chk_event_single: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (input_request_event || output_ready_event)
      |=> !input_request_event && !output_ready_event
   ) else $error("event held longer than one cycle");

   chk_twelve_words: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == ST_CFG && cnt_idx == 16'h000b && wr_cfg)
      |=> state_reg == ST_SP && input_request_event ||
          state_reg == ST_IDLE && status_reg[IRQ_ERR]
   ) else $error("config phase did not end after twelve words");

   chk_cfg_guard: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg != ST_CFG && wr_cfg && bus_addr == ADDR_CFG0)
      |=> $stable(cfg_reg[0]) && status_reg[IRQ_ERR]
   ) else $error("config written outside the config phase");

   chk_ready_after_data: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(output_ready_event) |->
         $past(state_reg) == ST_MAP || $past(state_reg) == ST_EXT
   ) else $error("output ready raised before inputs completed");

   chk_map_wait: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == ST_AP && cnt_last) |=>
         (state_reg == ST_MAP && !output_ready_event) [*8] ##9
         (state_reg == ST_EXT && output_ready_event)
   ) else $error("map pass length differs from its set time");

   chk_done_flag: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == ST_EXT && cnt_last && !output_params_flag)
      |=> status_reg[IRQ_DONE] && state_reg == ST_IDLE
   ) else $error("completion not flagged after extrinsic read");

   chk_parameter_ram_link: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == ST_EXT && cnt_last && output_params_flag)
      |=> output_ready_event && state_reg == ST_PARAMETER_RAM
   ) else $error("output parameter transfer not requested");

   chk_irq_follows: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (|(status_reg & mask_reg)) && !(bus_rd && bus_addr == ADDR_STATUS)
      |-> irq
   ) else $error("unmasked status without interrupt");
endmodule

// ==== rtl/word_counter.sv ====
// Transfer word counter with index and last-word flag.
`timescale 1ns/1ps
module word_counter #(
   parameter int CNT_W = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] len,
   input  wire logic             step,
   output logic      [CNT_W-1:0] idx,
   output logic                  last
);
   if (CNT_W < 2) begin : g_bad_width
      $error("word_counter needs CNT_W of at least 2");
   end

   logic [CNT_W-1:0] idx_reg;
   logic [CNT_W-1:0] idx_next;
   logic [CNT_W-1:0] len_reg;
   logic [CNT_W-1:0] len_next;

   always_comb begin
      idx_next = idx_reg;
      len_next = len_reg;
      if (load) begin
         idx_next = '0;
         len_next = len;
      end else if (step) begin
         idx_next = idx_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_reg <= '0;
         len_reg <= '0;
      end else begin
         idx_reg <= idx_next;
         len_reg <= len_next;
      end
   end

   assign idx  = idx_reg;
   assign last = step && (idx_reg == len_reg - 1'b1);
endmodule
